//--- design/main_clock_pkg.sv
`default_nettype none
package main_clock_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int TB_W          = 18;
  localparam int BEEP_W        = 16;
  localparam int TB_PERIOD_0   = 16000;
  localparam int TB_PERIOD_1   = 32000;
  localparam int TB_PERIOD_2   = 80000;
  localparam int TB_PERIOD_3   = 200000;
  // beep tones in hertz; counts are half periods of the square wave
  localparam int BEEP_HZ_0     = 2000;
  localparam int BEEP_HZ_1     = 1000;
  localparam int BEEP_HZ_2     = 500;
  localparam int BEEP_HALF_0   = CLK_HZ / (2 * BEEP_HZ_0);
  localparam int BEEP_HALF_1   = CLK_HZ / (2 * BEEP_HZ_1);
  localparam int BEEP_HALF_2   = CLK_HZ / (2 * BEEP_HZ_2);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int             ADDR_W         = 8;
  localparam logic [7:0]     CTRL_ADDR      = 8'h2c;
  localparam logic [7:0]     BEEP_ADDR      = 8'h2d;
  localparam logic [7:0]     IRQ_STAT_ADDR  = 8'h30;
  localparam logic [7:0]     IRQ_CLR_ADDR   = 8'h31;
  localparam logic [7:0]     IRQ_EN_ADDR    = 8'h32;
  localparam logic [7:0]     CTRL_RESET     = 8'h00;
  localparam logic [1:0]     BEEP_RESET     = 2'h0;
  localparam int             CLKOUT_EN_BIT  = 7;
  localparam int             DIV_LSB        = 5;
  localparam int             SLOW_BIT       = 4;
  localparam int             TB_LSB         = 2;
  localparam int             TICK_IE_BIT    = 1;
  localparam int             TICK_FLAG_BIT  = 0;
  localparam int             BEEP_LSB       = 0;
  localparam int             IRQ_W          = 2;
  localparam int             IRQ_TICK_BIT   = 0;
  localparam int             IRQ_TBSW_BIT   = 1;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_RUN   = 4'h1,
    MODE_WAIT  = 4'h2,
    MODE_AHALT = 4'h4,
    MODE_HALT  = 4'h8
  } mode_t;

endpackage
`default_nettype wire

//--- design/main_clock_unit.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - normal mode cpu clock equals oscillator clock
// - slow divider codes give divide 2/4/8/16
// - divider field only acts in slow mode
// - clock-out enable puts cpu clock on pin in slow mode, half oscillator clock in normal mode
// - clock-out suspended during active halt
// - time base codes select four counter periods
// - new time base applies after current period
// - flag set on period end, read clears
// - tick request only with interrupt enable
// - halt with enable set enters active halt
// - wait keeps running, tick wakes from wait
// - active halt: counter runs, tick wakes device
// - full halt freezes counter and registers
// - tick never wakes from full halt
// - beeper outputs three selectable tones
// - beep codes: off, 2k, 1k, 500 Hz
// - control/status register resets to zero
module main_clock_unit #(
  parameter int TB_PERIOD0 = main_clock_pkg::TB_PERIOD_0,
  parameter int TB_PERIOD1 = main_clock_pkg::TB_PERIOD_1,
  parameter int TB_PERIOD2 = main_clock_pkg::TB_PERIOD_2,
  parameter int TB_PERIOD3 = main_clock_pkg::TB_PERIOD_3,
  parameter int BEEP_HALF0 = main_clock_pkg::BEEP_HALF_0,
  parameter int BEEP_HALF1 = main_clock_pkg::BEEP_HALF_1,
  parameter int BEEP_HALF2 = main_clock_pkg::BEEP_HALF_2
) (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                reset,
  // register port
  input  wire logic [main_clock_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]                          regWrData,
  input  wire logic                                regWrite,
  input  wire logic                                regRead,
  output logic      [7:0]                          regRdData,
  // power mode requests from the core
  input  wire logic                                waitReq,
  input  wire logic                                haltReq,
  input  wire logic                                extWake,
  output var main_clock_pkg::mode_t                powerMode,
  // cpu clock enable
  output logic                                     cpuClkEn,
  // pins
  output logic                                     clockOutSel,
  output logic                                     clockOutLevel,
  output logic                                     beepSel,
  output logic                                     beepLevel,
  // interrupts
  output logic                                     tickReq,
  output logic                                     irq
);
  localparam int TB_W    = main_clock_pkg::TB_W;
  localparam int BEEP_W  = main_clock_pkg::BEEP_W;
  localparam int IRQ_W_L = main_clock_pkg::IRQ_W;
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TB_PERIOD0 < 2 || TB_PERIOD1 < 2 || TB_PERIOD2 < 2 || TB_PERIOD3 < 2 ||
      TB_PERIOD0 > 2**TB_W || TB_PERIOD1 > 2**TB_W ||
      TB_PERIOD2 > 2**TB_W || TB_PERIOD3 > 2**TB_W) begin : badTbPeriod
    $error("time base period out of counter range");
  end
  if (BEEP_HALF0 < 1 || BEEP_HALF1 < 1 || BEEP_HALF2 < 1 ||
      BEEP_HALF0 > 2**BEEP_W || BEEP_HALF1 > 2**BEEP_W ||
      BEEP_HALF2 > 2**BEEP_W) begin : badBeepHalf
    $error("beep half period out of counter range");
  end
  // ----------------------------------------------------------------
  // decoding functions
  // ----------------------------------------------------------------
  function automatic logic [TB_W-1:0] tbLastCount(input logic [1:0] code);
    unique case (code)
      2'h0: tbLastCount = TB_W'(TB_PERIOD0 - 1);
      2'h1: tbLastCount = TB_W'(TB_PERIOD1 - 1);
      2'h2: tbLastCount = TB_W'(TB_PERIOD2 - 1);
      2'h3: tbLastCount = TB_W'(TB_PERIOD3 - 1);
    endcase
  endfunction
  function automatic logic [BEEP_W-1:0] beepLastCount(input logic [1:0] code);
    unique case (code)
      2'h1:    beepLastCount = BEEP_W'(BEEP_HALF0 - 1);
      2'h2:    beepLastCount = BEEP_W'(BEEP_HALF1 - 1);
      2'h3:    beepLastCount = BEEP_W'(BEEP_HALF2 - 1);
      default: beepLastCount = '0;
    endcase
  endfunction
  // divide by 2^(code+1): enable when the low code+1 counter bits are all ones
  function automatic logic [3:0] divMask(input logic [1:0] code);
    unique case (code)
      2'h0: divMask = 4'h1;
      2'h1: divMask = 4'h3;
      2'h2: divMask = 4'h7;
      2'h3: divMask = 4'hf;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  main_clock_pkg::mode_t mode_r, mode_nxt;
  logic                  clkOutEn_r;
  logic [1:0]            divSel_r;
  logic                  slowMode_r;
  logic [1:0]            tbSel_r;
  logic                  tickIe_r;
  logic                  tickFlag_r;
  logic [1:0]            beepCode_r;
  logic [IRQ_W_L-1:0]    irqStatus_r;
  logic [IRQ_W_L-1:0]    irqEnable_r;
  logic [3:0]            divCnt_r;
  logic                  clkOutLevel_r;
  logic [TB_W-1:0]       tbCnt_r;
  logic [1:0]            tbActive_r;
  logic [BEEP_W-1:0]     beepCnt_r;
  logic                  beepLevel_r;
  logic [7:0]            regRdData_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic inRun      = (mode_r == main_clock_pkg::MODE_RUN);
  wire logic inWait     = (mode_r == main_clock_pkg::MODE_WAIT);
  wire logic inAhalt    = (mode_r == main_clock_pkg::MODE_AHALT);
  wire logic inHalt     = (mode_r == main_clock_pkg::MODE_HALT);
  // the core is stopped in both halt modes, so register writes and clearing reads are dropped
  wire logic regsLive   = inRun | inWait;
  wire logic hitCtrl    = (regAddr == main_clock_pkg::CTRL_ADDR);
  wire logic hitBeep    = (regAddr == main_clock_pkg::BEEP_ADDR);
  wire logic hitIrqStat = (regAddr == main_clock_pkg::IRQ_STAT_ADDR);
  wire logic hitIrqClr  = (regAddr == main_clock_pkg::IRQ_CLR_ADDR);
  wire logic hitIrqEn   = (regAddr == main_clock_pkg::IRQ_EN_ADDR);
  wire logic wrCtrl     = regWrite & regsLive & hitCtrl;
  wire logic wrBeep     = regWrite & regsLive & hitBeep;
  wire logic wrIrqClr   = regWrite & regsLive & hitIrqClr;
  wire logic wrIrqEn    = regWrite & regsLive & hitIrqEn;
  wire logic rdCtrl     = regRead & regsLive & hitCtrl;
  wire logic [7:0] ctrlWord = {clkOutEn_r, divSel_r, slowMode_r, tbSel_r, tickIe_r, tickFlag_r};

  // ----------------------------------------------------------------
  // cpu clock prescaler
  // ----------------------------------------------------------------
  wire logic [3:0] divMaskNow = divMask(divSel_r);
  wire logic       slowTick   = ((divCnt_r & divMaskNow) == divMaskNow);
  // the divider field is read only when slow mode is selected
  wire logic       cpuTick    = slowMode_r ? slowTick : 1'b1;

  assign cpuClkEn = regsLive & cpuTick;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      divCnt_r <= 4'h0;
    end else if (!inHalt) begin
      divCnt_r <= divCnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // clock-out
  // ----------------------------------------------------------------
  // a flop cannot copy the full-rate clock: in normal mode the pin toggles at
  // half the oscillator rate, in slow mode it carries the exact cpu rate
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clkOutLevel_r <= 1'b0;
    end else if (regsLive) begin
      clkOutLevel_r <= slowMode_r ? divCnt_r[divSel_r] : ~clkOutLevel_r;
    end
  end

  assign clockOutSel   = clkOutEn_r & ~inAhalt;
  assign clockOutLevel = clkOutLevel_r;

  // ----------------------------------------------------------------
  // time base counter
  // ----------------------------------------------------------------
  wire logic tbCounting = ~inHalt;
  wire logic tickEvent  = tbCounting & (tbCnt_r == tbLastCount(tbActive_r));
  wire logic tbSwitch   = tickEvent & (tbSel_r != tbActive_r);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tbCnt_r    <= '0;
      tbActive_r <= 2'h0;
    end else if (tickEvent) begin
      tbCnt_r    <= '0;
      tbActive_r <= tbSel_r;
    end else if (tbCounting) begin
      tbCnt_r    <= tbCnt_r + TB_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // control/status and beep registers
  // ----------------------------------------------------------------
  // the flag is set in hardware; a set in the same cycle as a clearing read wins
  wire logic tickFlag_nxt = tickEvent | (tickFlag_r & ~rdCtrl);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clkOutEn_r <= main_clock_pkg::CTRL_RESET[main_clock_pkg::CLKOUT_EN_BIT];
      divSel_r   <= main_clock_pkg::CTRL_RESET[main_clock_pkg::DIV_LSB +: 2];
      slowMode_r <= main_clock_pkg::CTRL_RESET[main_clock_pkg::SLOW_BIT];
      tbSel_r    <= main_clock_pkg::CTRL_RESET[main_clock_pkg::TB_LSB +: 2];
      tickIe_r   <= main_clock_pkg::CTRL_RESET[main_clock_pkg::TICK_IE_BIT];
      tickFlag_r <= main_clock_pkg::CTRL_RESET[main_clock_pkg::TICK_FLAG_BIT];
      beepCode_r <= main_clock_pkg::BEEP_RESET;
    end else begin
      tickFlag_r <= tickFlag_nxt;
      if (wrCtrl) begin
        clkOutEn_r <= regWrData[main_clock_pkg::CLKOUT_EN_BIT];
        divSel_r   <= regWrData[main_clock_pkg::DIV_LSB +: 2];
        slowMode_r <= regWrData[main_clock_pkg::SLOW_BIT];
        tbSel_r    <= regWrData[main_clock_pkg::TB_LSB +: 2];
        tickIe_r   <= regWrData[main_clock_pkg::TICK_IE_BIT];
      end
      if (wrBeep) begin
        beepCode_r <= regWrData[main_clock_pkg::BEEP_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign tickReq = tickFlag_r & tickIe_r;

  wire logic [IRQ_W_L-1:0] irqSet = {tbSwitch, tickEvent & tickIe_r};
  wire logic [IRQ_W_L-1:0] irqClr = wrIrqClr ? regWrData[IRQ_W_L-1:0] : '0;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStatus_r <= '0;
      irqEnable_r <= '0;
    end else begin
      irqStatus_r <= irqSet | (irqStatus_r & ~irqClr);
      if (wrIrqEn) begin
        irqEnable_r <= regWrData[IRQ_W_L-1:0];
      end
    end
  end
  assign irq = |(irqStatus_r & irqEnable_r);

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      main_clock_pkg::MODE_RUN: begin
        if (haltReq) begin
          mode_nxt = tickIe_r ? main_clock_pkg::MODE_AHALT
                              : main_clock_pkg::MODE_HALT;
        end else if (waitReq) begin
          mode_nxt = main_clock_pkg::MODE_WAIT;
        end
      end
      main_clock_pkg::MODE_WAIT: begin
        if (tickReq || extWake) begin
          mode_nxt = main_clock_pkg::MODE_RUN;
        end
      end
      main_clock_pkg::MODE_AHALT: begin
        if ((tickEvent && tickIe_r) || extWake) begin
          mode_nxt = main_clock_pkg::MODE_RUN;
        end
      end
      main_clock_pkg::MODE_HALT: begin
        if (extWake) begin
          mode_nxt = main_clock_pkg::MODE_RUN;
        end
      end
      default: mode_nxt = main_clock_pkg::MODE_RUN;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_r <= main_clock_pkg::MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  assign powerMode = mode_r;

  // ----------------------------------------------------------------
  // beeper
  // ----------------------------------------------------------------
  // still runs in active halt; software should switch it off there to save power
  wire logic beepOn   = (beepCode_r != 2'h0);
  wire logic beepWrap = (beepCnt_r == beepLastCount(beepCode_r));
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      beepCnt_r   <= '0;
      beepLevel_r <= 1'b0;
    end else if (!beepOn) begin
      beepCnt_r   <= '0;
      beepLevel_r <= 1'b0;
    end else if (!inHalt) begin
      beepCnt_r   <= beepWrap ? '0 : beepCnt_r + BEEP_W'(1);
      beepLevel_r <= beepLevel_r ^ beepWrap;
    end
  end

  assign beepSel   = beepOn;
  assign beepLevel = beepLevel_r;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire logic [7:0] rdMux =
      hitCtrl    ? ctrlWord :
      hitBeep    ? {6'h00, beepCode_r} :
      hitIrqStat ? {{(8 - IRQ_W_L){1'b0}}, irqStatus_r} :
      hitIrqEn   ? {{(8 - IRQ_W_L){1'b0}}, irqEnable_r} : 8'h00;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regRdData_r <= 8'h00;
    end else begin
      regRdData_r <= regRead ? rdMux : 8'h00;
    end
  end
  assign regRdData = regRdData_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence slowDiv2Run;
    slowMode_r && divSel_r == 2'h0 && inRun;
  endsequence
  AST_NORMAL_FULL_RATE: assert property ((inRun && !slowMode_r)
    |-> cpuClkEn) else $error("normal mode cpu enable missing");
  AST_SLOW_DIV2: assert property ((slowDiv2Run ##0 cpuClkEn) ##1 slowDiv2Run
    |-> !cpuClkEn ##1 (!inRun || !slowMode_r || divSel_r != 2'h0 || cpuClkEn))
    else $error("divide by two spacing wrong");
  AST_SLOW_DIV16: assert property ((inRun && slowMode_r && divSel_r == 2'h3 && cpuClkEn)
    |-> divCnt_r == 4'hf) else $error("divide by sixteen phase wrong");
  AST_CLKOUT_ON: assert property ((inRun && $past(wrCtrl) && $past(regWrData[7]))
    |-> clockOutSel) else $error("clock-out not selected after enable");
  AST_CLKOUT_AHALT: assert property (inAhalt
    |-> !clockOutSel) else $error("clock-out active in active halt");
  AST_TICK_PERIOD: assert property (tickEvent
    |-> tbCnt_r == tbLastCount(tbActive_r) ##1 (tbCnt_r == '0))
    else $error("time base period length wrong");
  AST_TB_DEFER: assert property ((!tickEvent && !reset)
    |=> $stable(tbActive_r)) else $error("time base changed mid period");
  AST_FLAG_SET: assert property (tickEvent
    |=> tickFlag_r) else $error("tick event lost");
  AST_READ_CLEAR: assert property ((rdCtrl && !tickEvent)
    |=> !tickFlag_r) else $error("flag not cleared by read");
  AST_REQ_GATED: assert property (tickReq
    |-> tickIe_r && tickFlag_r) else $error("tick request without enable");
  AST_AHALT_ENTRY: assert property ((inRun && haltReq && tickIe_r)
    |=> inAhalt) else $error("active halt not entered");
  AST_WAIT_WAKE: assert property ((inWait && tickReq)
    |=> inRun) else $error("tick did not leave wait");
  AST_AHALT_WAKE: assert property ((inAhalt && tickEvent && tickIe_r)
    |=> inRun && tickFlag_r) else $error("tick did not leave active halt");
  AST_HALT_FREEZE: assert property ((inHalt && !extWake)
    |=> $stable(tbCnt_r) && $stable(ctrlWord)) else $error("halt did not freeze counter");
  AST_HALT_NO_TICK: assert property ((inHalt && !extWake)
    |=> inHalt) else $error("left halt without external wake");
  AST_BEEP_OFF: assert property ((beepCode_r == 2'h0)
    |=> !beepLevel_r || beepOn) else $error("beep output while off");

endmodule // main_clock_unit
`default_nettype wire

//--- bench/pin_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------
// external device listening on an alternate-function pin
// -----------------------------------------------------------------
// it tracks the pin every cycle but counts edges only while the function is selected, so a level
// left over from GPIO use never counts as an edge
module pin_monitor (
  // clock
  input  wire logic clk,
  // pin
  input  wire logic sel,
  input  wire logic level,
  // measured half period in clocks, and edges seen
  output int        halfLen,
  output int        edges
);
  int   cnt = 0;
  logic prev = 1'b0;

  initial halfLen = 0;
  initial edges = 0;

  always @(posedge clk) begin
    if (sel && level !== prev) begin
      halfLen <= cnt;
      cnt     <= 1;
      edges   <= edges + 1;
    end else begin
      cnt <= cnt + 1;
    end
    prev <= level;
  end
endmodule // pin_monitor

`default_nettype wire

//--- bench/main_clock_unit_test.sv
`timescale 1ns/1ns
`default_nettype none

module main_clock_unit_test;
  // -----------------------------------------------------------------
  // signals and design
  // -----------------------------------------------------------------
  localparam int P [4]  = '{20, 40, 60, 80};
  localparam int BH [3] = '{3, 5, 7};
  logic                  sysClk, reset, regWrite, regRead, waitReq, haltReq, extWake;
  logic [7:0]            regAddr, regWrData, regRdData, rdv;
  main_clock_pkg::mode_t powerMode;
  logic                  cpuClkEn, clockOutSel, clockOutLevel, beepSel, beepLevel;
  logic                  tickReq, irq;
  int                    n_fail = 0, num_checks = 0, cyc = 0;
  int                    coHalf, coEdges, bpHalf, bpEdges, t0, t1, k;

  main_clock_unit #(.TB_PERIOD0(P[0]), .TB_PERIOD1(P[1]), .TB_PERIOD2(P[2]), .TB_PERIOD3(P[3]),
    .BEEP_HALF0(BH[0]), .BEEP_HALF1(BH[1]), .BEEP_HALF2(BH[2])) uut (
    .sys_clk(sysClk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .waitReq(waitReq),
    .haltReq(haltReq), .extWake(extWake), .powerMode(powerMode), .cpuClkEn(cpuClkEn),
    .clockOutSel(clockOutSel), .clockOutLevel(clockOutLevel), .beepSel(beepSel),
    .beepLevel(beepLevel), .tickReq(tickReq), .irq(irq));
  pin_monitor coMon (.clk(sysClk), .sel(clockOutSel), .level(clockOutLevel),
    .halfLen(coHalf), .edges(coEdges));
  pin_monitor bpMon (.clk(sysClk), .sel(beepSel), .level(beepLevel),
    .halfLen(bpHalf), .edges(bpEdges));

  initial begin
    sysClk = 1'b0;
    forever #20 sysClk = ~sysClk;
  end
  always @(posedge sysClk) cyc <= cyc + 1;

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge sysClk);
    regWrite <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sysClk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge sysClk);
    regRead <= 1'b0;
    #1;
    rdv = regRdData;
  endtask
  task automatic req(input logic h, input logic w, input logic x);
    @(posedge sysClk);
    haltReq <= h; waitReq <= w; extWake <= x;
    @(posedge sysClk);
    haltReq <= 1'b0; waitReq <= 1'b0; extWake <= 1'b0;
    #1;
  endtask
  task automatic waitTick(output int t);
    int n;
    n = 0;
    while (tickReq !== 1'b1 && n < 400) begin step(1); n++; end
    if (n >= 400) begin n_fail++; tally_and_finish(); end
    t = cyc;
  endtask
  task automatic waitMode(input main_clock_pkg::mode_t m, input int lim);
    int n;
    n = 0;
    while (powerMode !== m && n < lim) begin step(1); n++; end
    chk("wake mode", m, powerMode);
    if (n >= lim) tally_and_finish();
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic tCpuClock;
    for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) begin
      wr(main_clock_pkg::CTRL_ADDR, {1'b0, c[1:0], s[0], 4'h0});
      step(2);
      k = 0;
      repeat (64) begin step(1); if (cpuClkEn === 1'b1) k++; end
      chk("cpu enables per 64", (s == 1) ? 64 / (2 << c) : 64, k);
    end
  endtask
  // each new code is written inside a period, so the interval that
  // follows must still be the old code's period
  task automatic tTimeBase;
    int old;
    old = 0;
    wr(main_clock_pkg::CTRL_ADDR, 8'h02);
    rd(main_clock_pkg::CTRL_ADDR);
    waitTick(t0);
    for (int i = 0; i < 4; i++) begin
      wr(main_clock_pkg::CTRL_ADDR, {4'h0, 2'((i + 1) % 4), 2'h2});
      rd(main_clock_pkg::CTRL_ADDR);
      waitTick(t1);
      chk("tick interval", P[old], t1 - t0);
      t0 = t1;
      old = (i + 1) % 4;
    end
    rd(main_clock_pkg::IRQ_STAT_ADDR);
    chk("status switch", 1, rdv[main_clock_pkg::IRQ_TBSW_BIT]);
    rd(main_clock_pkg::CTRL_ADDR);
    waitTick(t0);
    rd(main_clock_pkg::CTRL_ADDR);
    chk("flag after tick", 1, rdv[0]);
    rd(main_clock_pkg::CTRL_ADDR);
    chk("flag after read", 0, rdv[0]);
    wr(main_clock_pkg::CTRL_ADDR, 8'h00);
    step(45);
    chk("request disabled", 0, tickReq);
    rd(main_clock_pkg::CTRL_ADDR);
    chk("flag without enable", 1, rdv[0]);
  endtask
  task automatic tIrq;
    wr(main_clock_pkg::IRQ_CLR_ADDR, 8'h03);
    wr(main_clock_pkg::CTRL_ADDR, 8'h02);
    rd(main_clock_pkg::CTRL_ADDR);
    waitTick(t0);
    rd(main_clock_pkg::IRQ_STAT_ADDR);
    chk("status tick", 1, rdv[0]);
    chk("irq masked", 0, irq);
    wr(main_clock_pkg::IRQ_EN_ADDR, 8'h01);
    chk("irq raised", 1, irq);
    wr(main_clock_pkg::IRQ_CLR_ADDR, 8'h01);
    chk("irq cleared", 0, irq);
    rd(8'h40);
    chk("unmapped read", 0, rdv);
  endtask
  task automatic tPins;
    wr(main_clock_pkg::CTRL_ADDR, 8'h80);
    step(20);
    chk("clock-out select", 1, clockOutSel);
    chk("clock-out half period", 1, coHalf);
    wr(main_clock_pkg::CTRL_ADDR, 8'h00);
    chk("clock-out released", 0, clockOutSel);
    for (int c = 1; c < 4; c++) begin
      wr(main_clock_pkg::BEEP_ADDR, 8'(c));
      step(40);
      chk("beep select", 1, beepSel);
      chk("beep half period", BH[c - 1], bpHalf);
    end
    wr(main_clock_pkg::BEEP_ADDR, 8'h00);
    step(2);
    chk("beep off", 0, {beepSel, beepLevel});
  endtask
  task automatic tPower;
    wr(main_clock_pkg::CTRL_ADDR, 8'h82);
    rd(main_clock_pkg::CTRL_ADDR);
    req(1'b1, 1'b0, 1'b0);
    chk("active halt", main_clock_pkg::MODE_AHALT, powerMode);
    chk("clock-out suspended", 0, clockOutSel);
    waitMode(main_clock_pkg::MODE_RUN, 100);
    wr(main_clock_pkg::CTRL_ADDR, 8'h00);
    req(1'b1, 1'b0, 1'b0);
    wr(main_clock_pkg::CTRL_ADDR, 8'hff);
    step(200);
    chk("full halt held", main_clock_pkg::MODE_HALT, powerMode);
    req(1'b0, 1'b0, 1'b1);
    waitMode(main_clock_pkg::MODE_RUN, 10);
    rd(main_clock_pkg::CTRL_ADDR);
    chk("frozen control", 0, rdv & 8'hfe);
    wr(main_clock_pkg::CTRL_ADDR, 8'h02);
    rd(main_clock_pkg::CTRL_ADDR);
    req(1'b0, 1'b1, 1'b0);
    chk("wait mode", main_clock_pkg::MODE_WAIT, powerMode);
    waitMode(main_clock_pkg::MODE_RUN, 100);
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    reset = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
    waitReq = 1'b0; haltReq = 1'b0; extWake = 1'b0;
    repeat (4) @(posedge sysClk);
    reset <= 1'b0;
    rd(main_clock_pkg::CTRL_ADDR);
    chk("control reset", 0, rdv);
    tCpuClock();
    tTimeBase();
    tIrq();
    tPins();
    tPower();
    tally_and_finish();
  end
endmodule // main_clock_unit_test

`default_nettype wire
